//--- ctu_params.svh
// Register offsets, field positions and reset values of the charge time unit
`ifndef CTU_PARAMS_SVH
`define CTU_PARAMS_SVH

`define CTU_ADDR_W 3
`define CTU_OFS_CTRL_HIGH 3'h0
`define CTU_OFS_CTRL_LOW 3'h1
`define CTU_OFS_CURRENT 3'h2
`define CTU_OFS_IRQ_STATUS 3'h3
`define CTU_OFS_IRQ_MASK 3'h4
`define CTU_RST_BYTE 8'h00
`define CTU_RST_WORD 32'h0000_0000

// Control high bits
`define CTU_BIT_UNIT_EN 7
`define CTU_BIT_DISCHARGE 1
// Control low bits
`define CTU_BIT_EDGE2 1
`define CTU_BIT_EDGE1 0
// Current control fields
`define CTU_TRIM_HI 7
`define CTU_TRIM_LO 2
`define CTU_RANGE_HI 1
`define CTU_RANGE_LO 0
// Event bits in status and mask
`define CTU_EVT_CHARGE_START 0
`define CTU_EVT_CHARGE_STOP 1
`define CTU_EVT_DRAIN_END 2
`define CTU_EVT_W 3
// Bus answer codes and the writable mask of control high
`define CTU_RESP_OKAY 2'h0
`define CTU_RESP_UNMAPPED 2'h3
`define CTU_CTRL_HIGH_MASK 8'hbf
// Trim codes, sign position and magnitude ends
`define CTU_TRIM_SIGN 5
`define CTU_TRIM_NOMINAL 6'h00
`define CTU_TRIM_POS_MAX 6'h1f
`define CTU_TRIM_NEG_MIN 6'h3f
`define CTU_TRIM_NEG_MAX 6'h21
`define CTU_TRIM_MAG_MIN 5'h01
`define CTU_TRIM_MAG_MAX 5'h1f
// Gain select codes driven to the current source
`define CTU_GAIN_X1 2'h0
`define CTU_GAIN_X10 2'h1
`define CTU_GAIN_X100 2'h2

`endif

//--- ctu_pkg.sv
// Types shared by the charge time unit
package ctu_pkg;
  typedef enum logic [1:0] {
    CTU_RANGE_OFF = 2'h0,
    CTU_RANGE_X1 = 2'h1,
    CTU_RANGE_X10 = 2'h2,
    CTU_RANGE_X100 = 2'h3
  } ctu_range_type;

  typedef struct packed {
    logic [5:0] trim;
    logic [1:0] range;
  } ctu_current_type;

  typedef struct packed {
    logic source_on;
    logic [1:0] gain_sel;
    logic trim_negative;
    logic [4:0] trim_mag;
    logic charge_on;
    logic drain_on;
  } ctu_analog_type;
endpackage

//--- ctu_charge_ctrl.sv
// Charge time unit control: register bank over Avalon-MM and analogue controls
`timescale 1ns/1ps
`include "ctu_params.svh"

module ctu_charge_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Avalon-MM slave
  input wire logic [`CTU_ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic [1:0] o_response,
  // Analogue controls
  output ctu_pkg::ctu_analog_type o_analog,
  // Interrupt
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [1:0] resp_reg;
  logic [7:0] ctrl_high_reg;
  logic [7:0] ctrl_low_reg;
  ctu_pkg::ctu_current_type current_reg;
  logic [`CTU_EVT_W-1:0] irq_status_reg;
  logic [`CTU_EVT_W-1:0] irq_mask_reg;

  wire req = (i_read | i_write) & ~ack_reg;
  wire wr_lane0 = i_write & ~ack_reg & i_byteenable[0];
  wire sel_high = i_address == `CTU_OFS_CTRL_HIGH;
  wire sel_low = i_address == `CTU_OFS_CTRL_LOW;
  wire sel_cur = i_address == `CTU_OFS_CURRENT;
  wire sel_stat = i_address == `CTU_OFS_IRQ_STATUS;
  wire sel_mask = i_address == `CTU_OFS_IRQ_MASK;
  wire mapped = sel_high | sel_low | sel_cur | sel_stat | sel_mask;

  // One wait cycle: the answer comes on the edge after the request is seen
  assign o_waitrequest = (i_read | i_write) & ~ack_reg;
  assign o_readdata = rdata_reg;
  assign o_response = resp_reg;

  function automatic logic [31:0] pad_byte(input logic [7:0] b);
    pad_byte = {24'h00_0000, b};
  endfunction

  wire [31:0] rd_mux = sel_high ? pad_byte(ctrl_high_reg) :
                       sel_low ? pad_byte(ctrl_low_reg) :
                       sel_cur ? pad_byte(current_reg) :
                       sel_stat ? pad_byte({5'h00, irq_status_reg}) :
                       sel_mask ? pad_byte({5'h00, irq_mask_reg}) : `CTU_RST_WORD;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_reg <= 1'b0;
      rdata_reg <= `CTU_RST_WORD;
      resp_reg <= 2'h0;
    end else begin
      ack_reg <= req;
      if (req) begin
        rdata_reg <= i_read ? rd_mux : `CTU_RST_WORD;
        resp_reg <= mapped ? `CTU_RESP_OKAY : `CTU_RESP_UNMAPPED;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  wire [7:0] wbyte = i_writedata[7:0];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_high_reg <= `CTU_RST_BYTE;
      ctrl_low_reg <= `CTU_RST_BYTE;
      current_reg <= `CTU_RST_BYTE;
      irq_mask_reg <= 3'h0;
    end else begin
      // Bit 6 of control high is unimplemented and stays zero
      if (wr_lane0 && sel_high) begin
        ctrl_high_reg <= wbyte & `CTU_CTRL_HIGH_MASK;
      end
      if (wr_lane0 && sel_low) begin
        ctrl_low_reg <= wbyte;
      end
      if (wr_lane0 && sel_cur) begin
        current_reg <= wbyte;
      end
      if (wr_lane0 && sel_mask) begin
        irq_mask_reg <= wbyte[`CTU_EVT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Analogue drive
  // ----------------------------------------------------------------
  wire unit_enable = ctrl_high_reg[`CTU_BIT_UNIT_EN];
  wire discharge_control = ctrl_high_reg[`CTU_BIT_DISCHARGE];
  wire edge_one_status = ctrl_low_reg[`CTU_BIT_EDGE1];
  wire [5:0] current_trim = current_reg.trim;
  ctu_pkg::ctu_range_type current_range;
  assign current_range = ctu_pkg::ctu_range_type'(current_reg.range);

  // Range decode to a gain select and a source enable
  wire source_on = unit_enable && (current_range != ctu_pkg::CTU_RANGE_OFF);
  wire [1:0] gain_sel = (current_range == ctu_pkg::CTU_RANGE_X100) ? `CTU_GAIN_X100 :
                        (current_range == ctu_pkg::CTU_RANGE_X10) ? `CTU_GAIN_X10 :
                        `CTU_GAIN_X1;
  // Two's complement trim: sign then magnitude; 100000 is not documented and is clamped
  wire trim_neg = current_trim[`CTU_TRIM_SIGN];
  wire [5:0] trim_abs = trim_neg ? (6'h00 - current_trim) : current_trim;
  wire [4:0] trim_mag = trim_abs[5] ? `CTU_TRIM_MAG_MAX : trim_abs[4:0];
  wire charge_on = unit_enable && source_on && edge_one_status;
  wire drain_on = unit_enable && discharge_control;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_analog <= '0;
    end else begin
      o_analog <= '{source_on, gain_sel, trim_neg, trim_mag, charge_on, drain_on};
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  logic charge_d_reg;
  logic drain_d_reg;
  wire [`CTU_EVT_W-1:0] events;
  assign events[`CTU_EVT_CHARGE_START] = charge_on & ~charge_d_reg;
  assign events[`CTU_EVT_CHARGE_STOP] = ~charge_on & charge_d_reg;
  assign events[`CTU_EVT_DRAIN_END] = ~drain_on & drain_d_reg;
  wire [`CTU_EVT_W-1:0] w1c = (wr_lane0 && sel_stat) ? wbyte[`CTU_EVT_W-1:0] : 3'h0;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      charge_d_reg <= 1'b0;
      drain_d_reg <= 1'b0;
      irq_status_reg <= 3'h0;
    end else begin
      charge_d_reg <= charge_on;
      drain_d_reg <= drain_on;
      // Set wins over a same-cycle clear
      irq_status_reg <= (irq_status_reg & ~w1c) | events;
    end
  end

  assign o_irq = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_cur_write;
    wr_lane0 && sel_cur;
  endsequence

  sequence s_high_write;
    wr_lane0 && sel_high;
  endsequence

  sequence s_low_write;
    wr_lane0 && sel_low;
  endsequence

  // Edge one cleared while charging; the stop event lands one edge later
  sequence s_charge_release;
    s_low_write ##0 !wbyte[`CTU_BIT_EDGE1] ##1 charge_d_reg;
  endsequence

  sequence s_charge_arm;
    s_low_write ##0 wbyte[`CTU_BIT_EDGE1] ##1 source_on;
  endsequence

  sequence s_drain_release;
    s_high_write ##0 !wbyte[`CTU_BIT_DISCHARGE] ##1 drain_d_reg;
  endsequence

  sequence s_drain_arm;
    s_high_write ##0 (wbyte[`CTU_BIT_UNIT_EN] && wbyte[`CTU_BIT_DISCHARGE]);
  endsequence

  // Write that must leave the control, current and mask registers alone
  sequence s_ignored_write;
    i_write && !ack_reg && (!i_byteenable[0] || !mapped);
  endsequence

  AST_TRIM_STORED: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_cur_write |=> current_reg.trim == $past(i_writedata[`CTU_TRIM_HI:`CTU_TRIM_LO]))
    else $error("Trim field not stored from bits 7-2");

  AST_TRIM_SIGN: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    1'b1 |=> o_analog.trim_negative == $past(current_reg.trim[5]))
    else $error("Trim sign wrong");

  AST_TRIM_NOMINAL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    current_reg.trim == 6'h00 |=> o_analog.trim_mag == 5'h00)
    else $error("Nominal trim not zero offset");

  AST_RANGE_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    current_reg.range == 2'h0 |=> !o_analog.source_on && !o_analog.charge_on)
    else $error("Source on with range disabled");

  AST_RANGE_X100: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    current_reg.range == 2'h3 |=> o_analog.gain_sel == 2'h2)
    else $error("Range 11 not decoded as 100x");

  AST_DRAIN: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_lane0 && sel_high ##1 1'b1 |=> o_analog.drain_on ==
      ($past(wbyte[`CTU_BIT_UNIT_EN], 2) && $past(wbyte[`CTU_BIT_DISCHARGE], 2)))
    else $error("Drain does not follow discharge bit");

  AST_CHARGE_STOP: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_lane0 && sel_low && !wbyte[0] ##1 1'b1 |=> !o_analog.charge_on)
    else $error("Charging did not stop on edge one clear");

  AST_EDGE_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_lane0 && sel_low |=> ctrl_low_reg[1:0] == $past(wbyte[1:0]))
    else $error("Edge status bits not written directly");

  AST_ACK_ONE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    req |=> !o_waitrequest)
    else $error("Answer not given one cycle after request");

  // ----------------------------------------------------------------
  // Bus, register, reset, range, trim, drive and event checks
  // ----------------------------------------------------------------
  // Answer code and data of the transfer taken on the last edge
  AST_RESP_OKAY: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    req && mapped |=> o_response == `CTU_RESP_OKAY)
    else $error("Mapped transfer not answered OKAY");

  AST_RESP_UNMAPPED: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    req && !mapped |=> o_response == `CTU_RESP_UNMAPPED && o_readdata == `CTU_RST_WORD)
    else $error("Unmapped transfer not refused");

  AST_READ_CURRENT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    req && i_read && sel_cur |=> o_readdata[7:0] == $past(current_reg))
    else $error("Current control read back wrong");

  // Read data and response stand until the next request is taken
  AST_READ_STANDS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !req |=> $stable(o_readdata) && $stable(o_response))
    else $error("Read data or response changed without a request");

  AST_BIT6_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    1'b1 |-> (ctrl_high_reg & ~`CTU_CTRL_HIGH_MASK) == 8'h00)
    else $error("Unimplemented control high bit set");

  AST_HIGH_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_high_write |=> ctrl_high_reg == ($past(wbyte) & `CTU_CTRL_HIGH_MASK))
    else $error("Control high not stored");

  AST_IGNORED_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_ignored_write |=> $stable(ctrl_high_reg) && $stable(ctrl_low_reg) &&
      $stable(current_reg) && $stable(irq_mask_reg))
    else $error("Register changed by an ignored write");

  // No disable here: it looks at the first edge after release
  AST_CUR_RESET: assert property (@(posedge i_clk)
    $rose(i_rst_b) |-> current_reg == `CTU_RST_BYTE && o_analog == '0)
    else $error("Current control or drive not zero after reset");

  AST_RANGE_X10: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    current_reg.range == ctu_pkg::CTU_RANGE_X10 |=> o_analog.gain_sel == `CTU_GAIN_X10)
    else $error("Range 10 not decoded as 10x");

  AST_RANGE_X1: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    current_reg.range == ctu_pkg::CTU_RANGE_X1 |=> o_analog.gain_sel == `CTU_GAIN_X1)
    else $error("Range 01 not decoded as base current");

  AST_RANGE_ON: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    unit_enable && current_range != ctu_pkg::CTU_RANGE_OFF |=> o_analog.source_on)
    else $error("Source off with a range selected");

  AST_DISABLED_QUIET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !unit_enable |=> !o_analog.source_on && !o_analog.charge_on && !o_analog.drain_on)
    else $error("Analogue drive active with unit disabled");

  AST_TRIM_POS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !current_reg.trim[`CTU_TRIM_SIGN] |=> !o_analog.trim_negative &&
      o_analog.trim_mag == $past(current_reg.trim[`CTU_TRIM_SIGN-1:0]))
    else $error("Positive trim magnitude wrong");

  AST_TRIM_POS_MAX: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    current_reg.trim == `CTU_TRIM_POS_MAX |=> o_analog.trim_mag == `CTU_TRIM_MAG_MAX)
    else $error("Largest positive trim wrong");

  AST_TRIM_NEG_MIN: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    current_reg.trim == `CTU_TRIM_NEG_MIN |=> o_analog.trim_mag == `CTU_TRIM_MAG_MIN)
    else $error("Smallest negative trim wrong");

  AST_TRIM_NEG_MAX: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    current_reg.trim == `CTU_TRIM_NEG_MAX |=> o_analog.trim_mag == `CTU_TRIM_MAG_MAX)
    else $error("Largest negative trim wrong");

  AST_DRAIN_START: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_drain_arm ##1 1'b1 |=> o_analog.drain_on)
    else $error("Drain not started by discharge bit");

  AST_DRAIN_END_EVT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_drain_release |=> irq_status_reg[`CTU_EVT_DRAIN_END] && !o_analog.drain_on)
    else $error("Drain end not recorded");

  AST_CHARGE_START: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_charge_arm |=> o_analog.charge_on)
    else $error("Charging not started by edge one");

  AST_CHARGE_START_EVT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_charge_arm ##0 !charge_d_reg |=> irq_status_reg[`CTU_EVT_CHARGE_START])
    else $error("Charge start not recorded");

  AST_CHARGE_STOP_EVT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_charge_release |=> irq_status_reg[`CTU_EVT_CHARGE_STOP])
    else $error("Charge stop not recorded");

  // Sticky status: a bit only falls when software writes a one to it
  AST_STATUS_STICKY: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    1'b1 |=> (($past(irq_status_reg) & ~$past(w1c)) & ~irq_status_reg) == '0)
    else $error("Status bit lost without a clear");

  AST_SET_WINS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    events != '0 |=> (irq_status_reg & $past(events)) == $past(events))
    else $error("Event not recorded in status");

  AST_W1C_CLEARS: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_lane0 && sel_stat && events == '0 |=> (irq_status_reg & $past(w1c)) == '0)
    else $error("Status bit not cleared by writing one");

  AST_MASK_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_lane0 && sel_mask |=> irq_mask_reg == $past(wbyte[`CTU_EVT_W-1:0]))
    else $error("Mask not stored");

endmodule // ctu_charge_ctrl

//--- ctu_charge_ctrl_test.sv
// Self-checking bench of the charge time unit register bank
`timescale 1ns/1ps
`include "ctu_params.svh"

module ctu_charge_ctrl_test;
  // ----------
  // Signals
  // ----------
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [`CTU_ADDR_W-1:0] i_address = '0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [3:0] i_byteenable = 4'hf;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic [1:0] o_response;
  ctu_pkg::ctu_analog_type o_analog;
  logic o_irq;
  logic [33:0] exp_q[$];
  logic [33:0] note;
  logic [31:0] rnd = 32'h0000_b9b4;
  logic [31:0] x;
  logic [7:0] cur;
  logic [7:0] tbl [8] = '{8'h7d, 8'h05, 8'h02, 8'hfe, 8'h87, 8'h01, 8'h00, 8'h03};
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;

  always #5 i_clk = ~i_clk;

  ctu_charge_ctrl i_ctu_charge_ctrl (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
    .o_response(o_response), .o_analog(o_analog), .o_irq(o_irq));

  // ----------
  // Tasks
  // ----------
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction

  task automatic fail(input string m);
    $display("unexpected at %0t: %s", $time, m);
    err_count++;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic we, input logic [2:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    i_address <= a;
    i_writedata <= {24'h0, d};
    i_byteenable <= be;
    i_read <= !we;
    i_write <= we;
    @(posedge i_clk);
    while (o_waitrequest !== 1'b0) @(posedge i_clk);
    i_read <= 1'b0;
    i_write <= 1'b0;
    @(posedge i_clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] d, input logic [1:0] r);
    exp_q.push_back({r, 24'h0, d});
    bus(1'b0, a, 8'h00, 4'hf);
  endtask

  task automatic chk_an(input logic [7:0] c, input logic en, input logic dis, input logic e1);
    logic [1:0] rg;
    logic [5:0] t;
    logic [4:0] mag;
    rg = c[1:0];
    t = c[7:2];
    mag = t[5] ? ((t == 6'h20) ? 5'h1f : 5'h00 - t[4:0]) : t[4:0];
    check_count++;
    if (!en) begin
      if (o_analog !== '0) fail("analog active while disabled");
    end else if (o_analog.source_on !== (rg != 2'h0) || o_analog.drain_on !== dis ||
                 o_analog.charge_on !== (e1 && rg != 2'h0)) fail("source, charge or drain");
    else if (rg != 2'h0 && (o_analog.gain_sel !== rg - 2'h1 ||
             o_analog.trim_negative !== t[5] || o_analog.trim_mag !== mag)) fail("gain or trim");
  endtask

  task automatic chk_irq(input logic e);
    check_count++;
    if (o_irq !== e) fail("irq level");
  endtask

  // ----------
  // Checking and sequence
  // ----------
  // Oldest note is compared when a read completes
  always @(posedge i_clk) begin
    if (i_read && o_waitrequest === 1'b0) begin
      check_count++;
      if (exp_q.size() == 0) fail("read without note");
      else begin
        note = exp_q.pop_front();
        if ({o_response, o_readdata} !== note) fail("read data or response");
      end
    end
  end

  // Run needs about 225 cycles; far margin against a stuck waitrequest
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail("timeout");
      tally_and_finish();
    end
  end

  initial begin
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    for (int a = 0; a < 5; a++) rd(a[2:0], 8'h00, 2'b00);
    chk_an(8'h00, 1'b0, 1'b0, 1'b0);
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00, 2'b11);
    $display("test reset and map done");
    wr(3'h0, 8'h80);
    cur = 8'h00;
    for (int i = 0; i < 20; i++) begin
      x = xs();
      if (i < 8) x = {20'h0, 4'hf, tbl[i]};
      bus(1'b1, 3'h2, x[7:0], x[11:8]);
      if (x[8]) cur = x[7:0];
      rd(3'h2, cur, 2'b00);
      chk_an(cur, 1'b1, 1'b0, 1'b0);
    end
    $display("test trim and range done");
    wr(3'h2, 8'h01);
    wr(3'h4, 8'h00);
    wr(3'h1, 8'h03);
    rd(3'h1, 8'h03, 2'b00);
    wr(3'h1, 8'h00);
    rd(3'h1, 8'h00, 2'b00);
    wr(3'h3, 8'h07);
    rd(3'h3, 8'h00, 2'b00);
    wr(3'h1, 8'h01);
    chk_an(8'h01, 1'b1, 1'b0, 1'b1);
    rd(3'h3, 8'h01, 2'b00);
    chk_irq(1'b0);
    wr(3'h4, 8'h07);
    chk_irq(1'b1);
    wr(3'h1, 8'h00);
    chk_an(8'h01, 1'b1, 1'b0, 1'b0);
    rd(3'h3, 8'h03, 2'b00);
    wr(3'h0, 8'h82);
    chk_an(8'h01, 1'b1, 1'b1, 1'b0);
    rd(3'h0, 8'h82, 2'b00);
    wr(3'h0, 8'h80);
    chk_an(8'h01, 1'b1, 1'b0, 1'b0);
    rd(3'h3, 8'h07, 2'b00);
    wr(3'h3, 8'h03);
    rd(3'h3, 8'h04, 2'b00);
    chk_irq(1'b1);
    wr(3'h4, 8'h03);
    chk_irq(1'b0);
    wr(3'h3, 8'h04);
    rd(3'h3, 8'h00, 2'b00);
    wr(3'h0, 8'h00);
    chk_an(8'h01, 1'b0, 1'b0, 1'b0);
    $display("test charge, drain and irq done");
    tally_and_finish();
  end
endmodule // ctu_charge_ctrl_test
